// ### src/rc_pkg.sv
// ------------------------------------------------------------
// Reset-cause status: shared constants
// ------------------------------------------------------------
package rc_pkg;

  localparam int unsigned NFLAG = 32;

  // Flag positions in the status word
  localparam int unsigned BIT_CFG_ERR      = 27;
  localparam int unsigned BIT_CFG_FAIL     = 26;
  localparam int unsigned BIT_CFG_MISMATCH = 9;
  localparam int unsigned BIT_EXT_PIN      = 7;
  localparam int unsigned BIT_SOFT         = 6;
  localparam int unsigned BIT_DEADMAN      = 5;
  localparam int unsigned BIT_WATCHDOG     = 4;
  localparam int unsigned BIT_SLEEP_WAKE   = 3;
  localparam int unsigned BIT_IDLE_WAKE    = 2;
  localparam int unsigned BIT_BROWNOUT     = 1;
  localparam int unsigned BIT_POWER_ON     = 0;

  // Implemented positions and reset value of the status word
  localparam logic [31:0] IMPL_MASK    = 32'h0C00_02FF;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0003;
  localparam logic [31:0] MASK_RESET   = 32'h0000_0000;

  // Register byte offsets
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_CLEAR  = 8'h04;
  localparam logic [7:0] OFF_MASK   = 8'h08;
  localparam logic [7:0] OFF_PEND   = 8'h0C;
  localparam logic [7:0] OFF_SWRST  = 8'h10;
  localparam logic [7:0] OFF_LAST   = 8'h14;

  // Software reset key, value arbitrary
  localparam logic [31:0] SWRST_KEY = 32'h0000_5A3C;

  // Last-cause record: bit 5 valid, bits 4:0 flag index
  localparam int unsigned LAST_W     = 6;
  localparam logic [5:0]  LAST_RESET = 6'h20;
  localparam logic [5:0]  LAST_VALID = 6'h20;

  // Power-saving state of the core
  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_IDLE  = 2'b01,
    PM_SLEEP = 2'b10
  } pwr_mode_t;

endpackage : rc_pkg

// ### src/flag_bus_if.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Flag bank carrier: set, clear and write strobes plus flags
// ------------------------------------------------------------
interface flag_bus_if;
  logic [31:0] set;   // Hardware event strobes
  logic [31:0] clr;   // Write-one-to-clear strobes
  logic [31:0] wr;    // Direct write enables
  logic [31:0] val;   // Direct write data
  logic [31:0] flags; // Current flags

  modport bank (input set, input clr, input wr, input val, output flags);
  modport ctl  (output set, output clr, output wr, output val, input flags);
endinterface : flag_bus_if
`default_nettype wire

// ### src/flag_bank.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Sticky flag bank, one flop per implemented position
// ------------------------------------------------------------
module flag_bank
  import rc_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  ce,
  // Strobes and flags
  flag_bus_if.bank   fb
);

  // Per bit: hardware set beats any clear or write of zero
  for (genvar i = 0; i < NFLAG; i++) begin : g_bit
    if (IMPL_MASK[i]) begin : g_impl
      logic flag_q;
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          flag_q <= STATUS_RESET[i];
        end else if (ce) begin
          if (fb.set[i]) begin
            flag_q <= 1'b1;
          end else if (fb.clr[i]) begin
            flag_q <= 1'b0;
          end else if (fb.wr[i]) begin
            flag_q <= fb.val[i];
          end
        end
      end
      assign fb.flags[i] = flag_q;
    end else begin : g_none
      assign fb.flags[i] = 1'b0;
    end
  end

endmodule : flag_bank
`default_nettype wire

// ### src/reset_cause_flags.sv
`timescale 1ns/10ps
`default_nettype none
module reset_cause_flags
  import rc_pkg::*;
#(
  parameter int unsigned ADR_W = 8
)(
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Event pulses from same-clock logic
  input  wire logic              cfg_read_err_evt,
  input  wire logic              cfg_dual_fail_evt,
  input  wire logic              cfg_mismatch_evt,
  input  wire logic              deadman_expire_evt,
  input  wire logic              watchdog_expire_evt,
  input  wire logic              brownout_evt,
  input  wire logic              power_on_evt,
  // Power-saving state levels from the core
  input  wire logic              pwr_idle,
  input  wire logic              pwr_sleep,
  // External pin, active low, asynchronous
  input  wire logic              master_clear_pin_n,
  // Outputs
  output logic                   soft_reset_req,
  output logic                   irq
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // Offsets fit one byte; address bits above it must be zero for a hit
  localparam int unsigned OFF_W = $bits(OFF_STATUS);

  if (ADR_W < OFF_W) begin : g_chk
    $error("reset_cause_flags: ADR_W must be at least 8");
  end

  // The last-cause record must hold any flag index plus its valid bit
  if (LAST_W < $clog2(NFLAG) + 1) begin : g_chk_last
    $error("reset_cause_flags: LAST_W too narrow for NFLAG");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  flag_bus_if fb ();

  logic              pin_s1_q;
  logic              pin_s2_q;
  logic              pin_s3_q;
  logic              pin_level_q;
  logic              ext_pin_evt;
  pwr_mode_t         pm_q;
  pwr_mode_t         pm_d;
  logic              idle_wake_evt;
  logic              sleep_wake_evt;
  logic              soft_evt;
  logic [31:0]       set_vec;
  logic [31:0]       mask_q;
  logic [31:0]       pend;
  logic [LAST_W-1:0] last_q;
  logic [LAST_W-1:0] last_d;
  logic              ack_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              req;
  logic              wr_req;
  logic              hit;
  logic [7:0]        adr_lo;
  logic [31:0]       lane;
  logic              soft_req_q;
  logic              irq_q;

  // ------------------------------------------------------------
  // Master clear pin synchroniser
  // ------------------------------------------------------------

  // Three flops; the first feeds only the second
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      pin_s3_q <= 1'b1;
    end else if (ce) begin
      pin_s1_q <= master_clear_pin_n;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Accepted level moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_level_q <= 1'b1;
    end else if (ce && (pin_s2_q == pin_s3_q)) begin
      pin_level_q <= pin_s3_q;
    end
  end

  // One event per accepted assertion; glitches shorter than a cycle die
  assign ext_pin_evt = (pin_s2_q == pin_s3_q) && !pin_s3_q && pin_level_q;

  // ------------------------------------------------------------
  // Power-saving state tracker
  // ------------------------------------------------------------

  // Sleep request outranks idle request
  always_comb begin
    pm_d = PM_RUN;
    if (pwr_sleep) begin
      pm_d = PM_SLEEP;
    end else if (pwr_idle) begin
      pm_d = PM_IDLE;
    end
  end

  // Remember the previous cycle's state to spot the return to run
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pm_q <= PM_RUN;
    end else if (ce) begin
      pm_q <= pm_d;
    end
  end

  // Wake is the return to run; a move idle to sleep is no wake
  always_comb begin
    idle_wake_evt  = 1'b0;
    sleep_wake_evt = 1'b0;
    case (pm_q)
      PM_IDLE: begin
        idle_wake_evt = (pm_d == PM_RUN);
      end
      PM_SLEEP: begin
        sleep_wake_evt = (pm_d == PM_RUN);
      end
      PM_RUN: begin
        idle_wake_evt  = 1'b0;
        sleep_wake_evt = 1'b0;
      end
      default: begin
        idle_wake_evt  = 1'b0;
        sleep_wake_evt = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Wishbone decode
  // ------------------------------------------------------------
  // Ack high gates req, so each request is taken exactly once
  assign adr_lo = wb_adr_i[OFF_W-1:0];
  assign hit    = ((wb_adr_i >> OFF_W) == '0);
  assign req    = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_req = req && wb_we_i && hit;
  assign lane   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Software reset only on the full key in all lanes
  assign soft_evt = wr_req && (adr_lo == OFF_SWRST) && (&wb_sel_i)
                    && (wb_dat_i == SWRST_KEY);

  // ------------------------------------------------------------
  // Event vector into the flag bank
  // ------------------------------------------------------------
  // Each cause drives its own flag position
  always_comb begin
    set_vec                   = '0;
    set_vec[BIT_CFG_ERR]      = cfg_read_err_evt;
    set_vec[BIT_CFG_FAIL]     = cfg_dual_fail_evt;
    set_vec[BIT_CFG_MISMATCH] = cfg_mismatch_evt;
    set_vec[BIT_EXT_PIN]      = ext_pin_evt;
    set_vec[BIT_SOFT]         = soft_evt;
    set_vec[BIT_DEADMAN]      = deadman_expire_evt;
    set_vec[BIT_WATCHDOG]     = watchdog_expire_evt;
    set_vec[BIT_SLEEP_WAKE]   = sleep_wake_evt;
    set_vec[BIT_IDLE_WAKE]    = idle_wake_evt;
    set_vec[BIT_BROWNOUT]     = brownout_evt;
    set_vec[BIT_POWER_ON]     = power_on_evt;
  end

  // Unimplemented positions never see a set strobe
  assign fb.set = set_vec & IMPL_MASK;

  // Clear alias: ones in enabled lanes clear; status write stores per lane
  assign fb.clr = (wr_req && (adr_lo == OFF_CLEAR)) ? (wb_dat_i & lane) : '0;
  assign fb.wr  = (wr_req && (adr_lo == OFF_STATUS)) ? lane : '0;
  assign fb.val = wb_dat_i;

  flag_bank u_bank (
    .mclk (mclk),
    .nrst (nrst),
    .ce   (ce),
    .fb   (fb)
  );

  // ------------------------------------------------------------
  // Mask, pending and interrupt
  // ------------------------------------------------------------

  // Mask is byte-lane writable; unimplemented positions stay zero
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mask_q <= MASK_RESET;
    end else if (ce && wr_req && (adr_lo == OFF_MASK)) begin
      mask_q <= ((mask_q & ~lane) | (wb_dat_i & lane)) & IMPL_MASK;
    end
  end

  // Only unmasked flags may raise the interrupt
  assign pend = fb.flags & mask_q;

  // Registered level; follows the flags one cycle late
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= |pend;
    end
  end

  // Level output straight from its flop, free of decode glitches
  assign irq = irq_q;

  // ------------------------------------------------------------
  // Last-cause record
  // ------------------------------------------------------------

  // Lowest set index wins when several events coincide
  always_comb begin
    last_d = last_q;
    for (int i = NFLAG - 1; i >= 0; i--) begin
      if (fb.set[i]) begin
        last_d = LAST_VALID | LAST_W'(i);
      end
    end
  end

  // Record survives clears of the status word; only reset reloads it, to valid with index 0
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      last_q <= LAST_RESET;
    end else if (ce) begin
      last_q <= last_d;
    end
  end

  // ------------------------------------------------------------
  // Software reset request
  // ------------------------------------------------------------

  // One-cycle pulse toward the reset controller
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      soft_req_q <= 1'b0;
    end else if (ce) begin
      soft_req_q <= soft_evt;
    end
  end

  // Registered so the reset controller sees one clean pulse
  assign soft_reset_req = soft_req_q;

  // ------------------------------------------------------------
  // Wishbone read data and acknowledge
  // ------------------------------------------------------------

  // Unmapped or write-only offsets read zero
  always_comb begin
    rdata_d = '0;
    if (hit) begin
      case (adr_lo)
        OFF_STATUS: begin
          rdata_d = fb.flags;
        end
        OFF_MASK: begin
          rdata_d = mask_q;
        end
        OFF_PEND: begin
          rdata_d = pend;
        end
        OFF_LAST: begin
          rdata_d = {{(32-LAST_W){1'b0}}, last_q};
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // Every request answered the next cycle, mapped or not
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= req;
    end
  end

  // Read data is held until the next read request
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (ce && req && !wb_we_i) begin
      rdata_q <= rdata_d;
    end
  end

  // Bus outputs come straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule : reset_cause_flags
`default_nettype wire

// ### verif/reset_cause_flags_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rcf_chk
  import rc_pkg::*;
#(
  parameter int unsigned ADR_W = 8
)(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             nrst,
  input wire logic             ce,
  // Register bus
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // Outputs
  input wire logic             soft_reset_req,
  input wire logic             irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Request decode; ack low means a new request is taken
  logic take;
  logic rd_null;
  logic key_wr;
  logic mask_off;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign rd_null = take && !wb_we_i && (wb_adr_i == ADR_W'(OFF_CLEAR) ||
                   wb_adr_i == ADR_W'(OFF_SWRST) || wb_adr_i > ADR_W'(OFF_LAST));
  assign key_wr = take && wb_we_i && wb_adr_i == ADR_W'(OFF_SWRST) &&
                  wb_sel_i == 4'hF && wb_dat_i == SWRST_KEY;
  assign mask_off = take && wb_we_i && wb_adr_i == ADR_W'(OFF_MASK) &&
                    wb_sel_i == 4'hF && wb_dat_i == 32'h0;

  bus_answer_a: assert property (take |=> wb_ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o && ce |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_quiet_a: assert property (disable iff (1'b0) !nrst |=>
    !wb_ack_o && !irq && !soft_reset_req && wb_dat_o == 32'h0)
    else $error("outputs active after reset");
  unimpl_zero_a: assert property (wb_ack_o |-> (wb_dat_o & ~IMPL_MASK) == 32'h0)
    else $error("unimplemented bit read as one");
  null_read_a: assert property (rd_null |=> wb_dat_o == 32'h0)
    else $error("write-only or unmapped read not zero");
  swrst_req_a: assert property (key_wr |=> ##[0:1] soft_reset_req)
    else $error("key write gave no reset request");
  swrst_pulse_a: assert property (soft_reset_req |=> !soft_reset_req)
    else $error("reset request longer than a pulse");
  swrst_cause_a: assert property ($rose(soft_reset_req) |->
    $past(key_wr, 1) || $past(key_wr, 2))
    else $error("reset request without key write");
  irq_mask_a: assert property (mask_off |=> ##1 !irq)
    else $error("interrupt with mask cleared");

  cov_key_c: cover property (key_wr);
  cov_irq_c: cover property ($rose(irq));
  cov_null_c: cover property (rd_null);
endmodule : rcf_chk
bind reset_cause_flags rcf_chk #(.ADR_W(ADR_W)) u_chk (.mclk, .nrst, .ce,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .soft_reset_req, .irq);
`default_nettype wire

// ### verif/test_reset_cause_flags.sv
`timescale 1ns/10ps
`default_nettype none
module test_reset_cause_flags
  import rc_pkg::*;
;
  logic mclk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, ack, irq, srq;
  logic idle = 0, slp = 0, pin_n = 1, ce = 1;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, dout, rdat, m_st, m_mk, d, lm;
  logic [6:0] ev = 7'h00;
  int fail_count = 0, samples_checked = 0, srq_n = 0, seed = 32'h1B03, i;
  int bits [7] = '{27, 26, 9, 5, 4, 1, 0};

  reset_cause_flags dut (.mclk(mclk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
    .cfg_read_err_evt(ev[0]), .cfg_dual_fail_evt(ev[1]), .cfg_mismatch_evt(ev[2]),
    .deadman_expire_evt(ev[3]), .watchdog_expire_evt(ev[4]),
    .brownout_evt(ev[5]), .power_on_evt(ev[6]), .pwr_idle(idle),
    .pwr_sleep(slp), .master_clear_pin_n(pin_n), .soft_reset_req(srq), .irq(irq));

  // 200 MHz clock; reset-request pulses counted for comparison
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (srq === 1'b1) srq_n++;

  function automatic logic [31:0] evm(input logic [6:0] e);
    logic [31:0] m;
    m = 32'h0;
    for (int j = 0; j < 7; j++) if (e[j]) m[bits[j]] = 1'b1;
    return m;
  endfunction : evm

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Classic single cycle; event strobes ride on the taking edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd,
                     input logic [3:0] s, input logic [6:0] e);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= dd;
    sel <= s;
    ev <= e;
    @(posedge mclk);
    ev <= 7'h00;
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge mclk);
    end
    if (n == 20) fail_count++;
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hF, 7'h00);
    chk(rdat, e);
  endtask : rdc

  // Status write: lanes store, events win over cleared bits
  task automatic wst(input logic [31:0] dd, input logic [3:0] s, input logic [6:0] e);
    bus(1'b1, OFF_STATUS, dd, s, e);
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    m_st = ((m_st & ~lm) | (dd & lm) | evm(e)) & IMPL_MASK;
  endtask : wst

  task automatic pulse(input logic [6:0] e);
    ev <= e;
    @(posedge mclk);
    ev <= 7'h00;
    @(posedge mclk);
  endtask : pulse

  task automatic conclude;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // Watchdog on the whole run
  initial begin
    #20000;
    fail_count++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    m_st = STATUS_RESET;
    m_mk = MASK_RESET;
    rdc(OFF_STATUS, m_st);
    rdc(OFF_MASK, m_mk);
    rdc(OFF_LAST, 32'(LAST_RESET));
    bus(1'b1, 8'h40, 32'hFFFFFFFF, 4'hF, 7'h00);
    rdc(8'h40, 32'h0);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      wst(32'h0, 4'hF, 7'h00);
      pulse(7'(1 << i));
      m_st = m_st | evm(7'(1 << i));
      rdc(OFF_STATUS, m_st);
    end
    idle <= 1'b1;
    repeat (3) @(posedge mclk);
    idle <= 1'b0;
    repeat (2) @(posedge mclk);
    slp <= 1'b1;
    repeat (3) @(posedge mclk);
    slp <= 1'b0;
    pin_n <= 1'b0;
    repeat (6) @(posedge mclk);
    pin_n <= 1'b1;
    repeat (6) @(posedge mclk);
    bus(1'b1, OFF_SWRST, 32'h0000_1111, 4'hF, 7'h00);
    chk(32'(srq_n), 32'h0);
    bus(1'b1, OFF_SWRST, SWRST_KEY, 4'hF, 7'h00);
    chk(32'(srq_n), 32'h1);
    m_st = m_st | 32'hCC;
    rdc(OFF_STATUS, m_st);
    $display("test events done");
    wst(32'h0, 4'hF, 7'h40);
    rdc(OFF_STATUS, m_st);
    bus(1'b1, OFF_CLEAR, 32'h1, 4'hF, 7'h20);
    m_st = 32'h2;
    rdc(OFF_STATUS, m_st);
    pulse(7'h40);
    m_st = 32'h3;
    rdc(OFF_STATUS, m_st);
    // Clock enable low: an event pulse must leave every flag frozen
    ce <= 1'b0;
    pulse(7'h10);
    ce <= 1'b1;
    rdc(OFF_STATUS, m_st);
    $display("test clear done");
    bus(1'b1, OFF_MASK, 32'hFFFF_FF10, 4'h1, 7'h00);
    m_mk = 32'h10;
    rdc(OFF_MASK, m_mk);
    pulse(7'h10);
    @(posedge mclk);
    chk(32'(irq), 32'h1);
    m_st = m_st | 32'h10;
    rdc(OFF_PEND, m_st & m_mk);
    bus(1'b1, OFF_CLEAR, 32'h10, 4'hF, 7'h00);
    pulse(7'h20);
    @(posedge mclk);
    chk(32'(irq), 32'h0);
    rdc(OFF_LAST, 32'(LAST_VALID | 6'(BIT_BROWNOUT)));
    bus(1'b1, OFF_MASK, 32'h0, 4'hF, 7'h00);
    $display("test irq done");
    m_st = m_st & ~32'h10;
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      wst(d, 4'($random(seed)), 7'($random(seed)));
      rdc(OFF_STATUS, m_st);
    end
    $display("test random done");
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    rdc(OFF_STATUS, STATUS_RESET);
    $display("test rerun done");
    conclude();
  end
endmodule : test_reset_cause_flags
`default_nettype wire
